//--- src/charge_cycle_sequencer.sv
// Charge cycle sequencer: charge states, status pin and AHB-Lite registers
//
// Local design decisions: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module charge_cycle_sequencer
  import charge_cycle_pkg::*;
#(
  parameter int PULSE_CYCLES = FAULT_PULSE_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        hardwareOffInput,
  input  wire logic        belowDeepDischarge,
  input  wire logic        nearTarget,
  input  wire logic        belowRecharge,
  input  wire logic        taperCutoffReached,
  input  wire logic        dieHot,
  input  wire logic        batteryConfirmed,
  input  wire logic        faultEvent,
  output logic             statOut,
  output logic             statOe,
  output logic      [11:0] chargeCurrentMa,
  output logic             cvMode,
  output logic             floatMode,
  output logic      [15:0] cellTargetVoltage,
  output logic             irq
);

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  logic [7:0] pinsRaw;
  logic [7:0] pins;
  logic       offSync;
  logic       deepSync;
  logic       nearSync;
  logic       rechargeSync;
  logic       taperSync;
  logic       hotSync;
  logic       confirmSync;
  logic       faultSync;
  logic       faultSyncDly;

  assign pinsRaw = {faultEvent, batteryConfirmed, dieHot, taperCutoffReached,
                    belowRecharge, nearTarget, belowDeepDischarge, hardwareOffInput};

  pin_sync #(
    .WIDTH (8)
  ) u_pin_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pinIn   (pinsRaw),
    .pinOut  (pins)
  );

  assign {faultSync, confirmSync, hotSync, taperSync,
          rechargeSync, nearSync, deepSync, offSync} = pins;

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  logic                  dataWrite;
  logic [7:0]            dataAddr;
  logic                  addrPhase;
  logic [CTRL_WIDTH-1:0] ctrl;
  logic [15:0]           target;
  logic [11:0]           bulk;
  logic [1:0]            foldShift;
  logic [IRQ_WIDTH-1:0]  irqStatus;
  logic [IRQ_WIDTH-1:0]  irqMask;
  logic [IRQ_WIDTH-1:0]  irqEvents;
  logic                  faultLatched;
  charge_state_t         state;
  charge_state_t         next_state;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addrPhase = hsel && htrans[1] && hready;

  function automatic logic [31:0] readMux(input logic [7:0] addr);
    logic [31:0] value;
    value = 32'h0000_0000;
    unique case (addr)
      OFS_CTRL:       value[CTRL_WIDTH-1:0] = ctrl;
      OFS_TARGET:     value[15:0] = target;
      OFS_BULK:       value[11:0] = bulk;
      OFS_FOLD:       value[1:0] = foldShift;
      OFS_STATE: begin
        value[2:0]            = state;
        value[STATE_FAULT_BIT] = faultLatched;
        value[STATE_CV_BIT]    = cvMode;
        value[STATE_HOT_BIT]   = hotSync;
      end
      OFS_IRQ_STATUS: value[IRQ_WIDTH-1:0] = irqStatus;
      OFS_IRQ_MASK:   value[IRQ_WIDTH-1:0] = irqMask;
      default:        value = 32'h0000_0000;
    endcase
    return value;
  endfunction : readMux

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dataWrite <= 1'b0;
      dataAddr  <= 8'h00;
    end else if (hready) begin
      dataWrite <= addrPhase && hwrite;
      dataAddr  <= haddr[7:0];
    end
  end

  // Read data is captured at the address phase so it stands as a flop
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (addrPhase && !hwrite) begin
      hrdata <= readMux(haddr[7:0]);
    end
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************
  logic ctrlWrite;
  logic restartReq;
  logic targetOk;

  assign ctrlWrite = dataWrite && (dataAddr == OFS_CTRL);
  assign targetOk  = (hwdata[15:0] >= TARGET_MIN_MV) && (hwdata[15:0] <= TARGET_MAX_MV);

  // Toggles of inhibit or float request, or a reset bit write
  assign restartReq = ctrlWrite &&
                      ((hwdata[CTRL_INHIBIT] != ctrl[CTRL_INHIBIT]) ||
                       hwdata[CTRL_RESET] ||
                       (hwdata[CTRL_FLOAT_REQ] != ctrl[CTRL_FLOAT_REQ]));

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl <= CTRL_RESET_VALUE;
    end else if (ctrlWrite) begin
      ctrl <= hwdata[CTRL_WIDTH-1:0];
      ctrl[CTRL_RESET] <= 1'b0;
    end
  end

  // Out-of-range targets are dropped; the old value stays in force
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      target <= TARGET_RESET_MV;
    end else if (dataWrite && (dataAddr == OFS_TARGET) && targetOk) begin
      target <= hwdata[15:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bulk      <= BULK_RESET_MA;
      foldShift <= FOLD_RESET_SHIFT;
    end else if (dataWrite && (dataAddr == OFS_BULK)) begin
      bulk <= hwdata[11:0];
    end else if (dataWrite && (dataAddr == OFS_FOLD)) begin
      foldShift <= hwdata[1:0];
    end
  end

  assign cellTargetVoltage = target;

  // ****************************************************************
  // Charge sequence
  // ****************************************************************
  logic offRequest;
  logic charging;
  logic faultRise;
  logic terminate;
  logic found;
  logic [2:0] settleCnt;

  // Pins read zero until the synchroniser fills; idle waits that out
  localparam logic [2:0] SETTLE_DONE = 3'(SYNC_STAGES + 1);

  assign offRequest = offSync || ctrl[CTRL_FLOAT_REQ] || ctrl[CTRL_INHIBIT];
  assign faultRise  = faultSync && !faultSyncDly;
  assign terminate  = (state == ST_VOLTAGE) && taperSync && !rechargeSync &&
                      ctrl[CTRL_END_ALLOW];
  assign found      = (state == ST_DETECT) && confirmSync;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      faultSyncDly <= 1'b0;
    end else begin
      faultSyncDly <= faultSync;
    end
  end

  // Without this a deep-discharged cell would see bulk current for a few cycles
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      settleCnt <= 3'h0;
    end else if (settleCnt != SETTLE_DONE) begin
      settleCnt <= settleCnt + 3'h1;
    end
  end

  always_comb begin
    next_state = state;
    if (offRequest) begin
      next_state = ST_FLOAT;
    end else if (restartReq) begin
      next_state = ST_PRECHARGE;
    end else begin
      unique case (state)
        ST_IDLE:      if (settleCnt == SETTLE_DONE) next_state = ST_PRECHARGE;
        ST_FLOAT:     next_state = ST_PRECHARGE;
        ST_PRECHARGE: if (!deepSync) next_state = ST_FAST;
        ST_FAST: begin
          if (deepSync) begin
            next_state = ST_PRECHARGE;
          end else if (nearSync) begin
            next_state = ST_VOLTAGE;
          end
        end
        ST_VOLTAGE: begin
          if (terminate) begin
            next_state = ST_DETECT;
          end else if (!nearSync) begin
            next_state = ST_FAST;
          end
        end
        ST_DETECT: begin
          if (!ctrl[CTRL_END_ALLOW]) begin
            next_state = ST_VOLTAGE;
          end else if (confirmSync || rechargeSync) begin
            next_state = ST_PRECHARGE;
          end
        end
        default:      next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Fault stays latched until a battery is confirmed in the detect state
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      faultLatched <= 1'b0;
    end else if (faultRise) begin
      faultLatched <= 1'b1;
    end else if (found) begin
      faultLatched <= 1'b0;
    end
  end

  // ****************************************************************
  // Current command
  // ****************************************************************
  logic [11:0] next_current;

  assign charging = (state == ST_PRECHARGE) || (state == ST_FAST) ||
                    (state == ST_VOLTAGE);

  always_comb begin
    next_current = 12'h000;
    // Follows next_state so current and mode flags change on one edge
    if (next_state == ST_PRECHARGE) begin
      next_current = PRECHARGE_MA;
    end else if ((next_state == ST_FAST) || (next_state == ST_VOLTAGE)) begin
      next_current = bulk;
    end
    // Coarse shift fold-back; the analog loop trims the rest
    if (hotSync && (next_state != ST_PRECHARGE)) begin
      next_current = next_current >> foldShift;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      chargeCurrentMa <= 12'h000;
      cvMode          <= 1'b0;
      floatMode       <= 1'b0;
    end else begin
      chargeCurrentMa <= next_current;
      cvMode          <= (next_state == ST_VOLTAGE);
      floatMode       <= (next_state == ST_FLOAT);
    end
  end

  // ****************************************************************
  // Status pin
  // ****************************************************************
  logic pulseActive;

  pulse_timer #(
    .CYCLES (PULSE_CYCLES)
  ) u_pulse_timer (
    .clk_sys (clk_sys),
    .rst     (rst),
    .fire    (faultRise),
    .active  (pulseActive)
  );

  // Open drain: only ever pulls low
  assign statOut = 1'b0;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      statOe <= 1'b0;
    end else begin
      statOe <= ctrl[CTRL_STAT_ALLOW] && (charging || pulseActive);
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  assign irqEvents[IRQ_FAULT]         = faultRise;
  assign irqEvents[IRQ_TERMINATED]    = terminate;
  assign irqEvents[IRQ_BATTERY_FOUND] = found && ctrl[CTRL_END_ALLOW];
  assign irqEvents[IRQ_NEW_CYCLE]     = (next_state == ST_PRECHARGE) &&
                                        (state != ST_PRECHARGE);

  // A new event outranks a write-one clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irqStatus <= '0;
    end else if (dataWrite && (dataAddr == OFS_IRQ_STATUS)) begin
      irqStatus <= (irqStatus & ~hwdata[IRQ_WIDTH-1:0]) | irqEvents;
    end else begin
      irqStatus <= irqStatus | irqEvents;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irqMask <= '0;
    end else if (dataWrite && (dataAddr == OFS_IRQ_MASK)) begin
      irqMask <= hwdata[IRQ_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus & irqMask);
    end
  end

  logic unusedBits;
  assign unusedBits = ^{haddr[31:8], hsize, hwdata[31:16]};

endmodule : charge_cycle_sequencer
`default_nettype wire

//--- src/charge_cycle_pkg.sv
// Constants and types shared by the charge cycle sequencer
package charge_cycle_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_TARGET     = 8'h04;
  localparam logic [7:0] OFS_BULK       = 8'h08;
  localparam logic [7:0] OFS_FOLD       = 8'h0C;
  localparam logic [7:0] OFS_STATE      = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h18;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int CTRL_STAT_ALLOW   = 0;
  localparam int CTRL_END_ALLOW    = 1;
  localparam int CTRL_INHIBIT      = 2;
  localparam int CTRL_RESET        = 3;
  localparam int CTRL_FLOAT_REQ    = 4;
  localparam int CTRL_WIDTH        = 5;
  localparam logic [4:0] CTRL_RESET_VALUE = 5'h03;

  // ****************************************************************
  // Status and interrupt fields
  // ****************************************************************
  localparam int STATE_FAULT_BIT   = 4;
  localparam int STATE_CV_BIT      = 5;
  localparam int STATE_HOT_BIT     = 6;
  localparam int IRQ_FAULT         = 0;
  localparam int IRQ_TERMINATED    = 1;
  localparam int IRQ_BATTERY_FOUND = 2;
  localparam int IRQ_NEW_CYCLE     = 3;
  localparam int IRQ_WIDTH         = 4;

  // ****************************************************************
  // Analog setpoints and limits
  // ****************************************************************
  localparam logic [15:0] TARGET_MIN_MV     = 16'h0DAC;  // 3500 mV
  localparam logic [15:0] TARGET_MAX_MV     = 16'h1158;  // 4440 mV
  localparam logic [15:0] TARGET_RESET_MV   = 16'h0E10;  // 3600 mV
  localparam logic [11:0] PRECHARGE_MA      = 12'h032;   // 50 mA
  localparam logic [11:0] BULK_RESET_MA     = 12'h3E8;   // 1000 mA
  localparam logic [1:0]  FOLD_RESET_SHIFT  = 2'h1;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_FREQ_KHZ      = 10000;
  localparam int FAULT_PULSE_US    = 128;
  localparam int FAULT_PULSE_CYC   = (FAULT_PULSE_US * CLK_FREQ_KHZ) / 1000;
  localparam int SYNC_STAGES       = 3;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_PRECHARGE = 3'b001,
    ST_FAST      = 3'b010,
    ST_VOLTAGE   = 3'b011,
    ST_DETECT    = 3'b100,
    ST_FLOAT     = 3'b101
  } charge_state_t;

endpackage : charge_cycle_pkg

//--- src/pin_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import charge_cycle_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinOut
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A bit moves only once the two settled stages agree
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pinOut <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          pinOut[i] <= stage3[i];
        end
      end
    end
  end
endmodule : pin_sync
`default_nettype wire

//--- src/pulse_timer.sv
// Retriggerable one-shot that times the fault pulse
`timescale 1ns/1ps
`default_nettype none
module pulse_timer
  import charge_cycle_pkg::*;
#(
  parameter int CYCLES = FAULT_PULSE_CYC
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic fire,
  output logic      active
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);

  logic [CW-1:0] remaining;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      remaining <= '0;
    end else if (fire) begin
      remaining <= LOAD;
    end else if (remaining != '0) begin
      remaining <= remaining - CW'(1);
    end
  end

  assign active = (remaining != '0);
endmodule : pulse_timer
`default_nettype wire

//--- dv/charge_cycle_sva.sv
// Port-level assertions for the charge cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module charge_cycle_sva
  import charge_cycle_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        statOut,
  input wire logic        statOe,
  input wire logic [11:0] chargeCurrentMa,
  input wire logic        cvMode,
  input wire logic        floatMode,
  input wire logic [15:0] cellTargetVoltage,
  input wire logic        irq,
  input wire logic        hardwareOffInput,
  input wire logic        belowDeepDischarge
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_open_drain: assert property (statOut == 1'b0)
    else $error("status pin data not low");
  a_target_range: assert property (cellTargetVoltage >= TARGET_MIN_MV &&
    cellTargetVoltage <= TARGET_MAX_MV)
    else $error("target voltage out of range");
  a_off_forces_float: assert property (hardwareOffInput [*8] |-> floatMode)
    else $error("off input did not force high impedance");
  a_float_no_charge: assert property (floatMode |-> chargeCurrentMa == 12'h000 && !cvMode)
    else $error("current commanded in high impedance");
  // Reset must clear outputs even though reset disables the others
  a_reset_quiet: assert property (disable iff (1'b0) rst |=>
    !statOe && chargeCurrentMa == 12'h000 && !floatMode && !irq)
    else $error("outputs not idle after reset");
  a_precharge_fixed: assert property (belowDeepDischarge [*8] &&
    chargeCurrentMa != 12'h000 |-> chargeCurrentMa == PRECHARGE_MA)
    else $error("pre-charge current wrong");
  a_cv_charging: assert property ($rose(cvMode) |-> !floatMode && $stable(floatMode))
    else $error("voltage regulation outside charge state");

  c_float: cover property ($rose(floatMode));
  c_cv: cover property ($rose(cvMode));
  c_stat: cover property ($fell(statOe));
  c_irq: cover property ($rose(irq));
endmodule : charge_cycle_sva

bind charge_cycle_sequencer charge_cycle_sva u_sva (
  .clk_sys(clk_sys), .rst(rst), .hreadyout(hreadyout), .hresp(hresp),
  .statOut(statOut), .statOe(statOe), .chargeCurrentMa(chargeCurrentMa),
  .cvMode(cvMode), .floatMode(floatMode), .cellTargetVoltage(cellTargetVoltage),
  .irq(irq), .hardwareOffInput(hardwareOffInput), .belowDeepDischarge(belowDeepDischarge)
);
`default_nettype wire

//--- dv/host_model.sv
// Host side of the status pin: pull-up and low pulse width meter
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic        clk_sys,
  input  wire logic        statOut,
  input  wire logic        statOe,
  output logic             statPin,
  output logic      [15:0] lastLow
);
  logic [15:0] lowRun = 16'h0000;
  // Pull-up resistor: released pin reads high
  assign statPin = statOe ? statOut : 1'b1;
  initial lastLow = 16'h0000;
  always @(posedge clk_sys) begin
    if (!statPin) begin
      lowRun <= lowRun + 16'h0001;
    end else if (lowRun != 16'h0000) begin
      lastLow <= lowRun;
      lowRun  <= 16'h0000;
    end
  end
endmodule : host_model
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench for the charge cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import charge_cycle_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic hreadyout, hresp, statOut, statOe, cvMode, floatMode, irq, statPin;
  logic offIn = 1'b0, deep = 1'b1, near = 1'b0, rech = 1'b0, taper = 1'b0;
  logic hot = 1'b0, conf = 1'b0, fault = 1'b0;
  logic [11:0] curMa;
  logic [15:0] target, lastLow;
  int error_cnt = 0, num_checks = 0;

  charge_cycle_sequencer #(.PULSE_CYCLES(20)) DUT (.clk_sys(clk_sys), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .hardwareOffInput(offIn), .belowDeepDischarge(deep),
    .nearTarget(near), .belowRecharge(rech), .taperCutoffReached(taper),
    .dieHot(hot), .batteryConfirmed(conf), .faultEvent(fault), .statOut(statOut),
    .statOe(statOe), .chargeCurrentMa(curMa), .cvMode(cvMode), .floatMode(floatMode),
    .cellTargetVoltage(target), .irq(irq));
  host_model u_host (.clk_sys(clk_sys), .statOut(statOut), .statOe(statOe),
    .statPin(statPin), .lastLow(lastLow));

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wt
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1; haddr <= {24'h00_0000, a}; htrans <= 2'h2; hwrite <= w;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
  endtask : bus
  task automatic fpulse();
    fault <= 1'b1; wt(6); fault <= 1'b0; wt(4);
  endtask : fpulse

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    bus(OFS_CTRL, 0, 0); chk(rd, 32'h0000_0003);
    bus(OFS_BULK, 0, 0); chk(rd, 32'h0000_03E8);
    bus(OFS_FOLD, 0, 0); chk(rd, 32'h0000_0001);
    bus(8'h1C, 1, 32'h0000_FFFF); bus(8'h1C, 0, 0); chk(rd, 32'h0000_0000);
    wt(8); chk(curMa, PRECHARGE_MA); chk(statPin, 0);
  endtask : t_regs
  task automatic t_fast();
    deep <= 1'b0; wt(10); chk(curMa, 12'h3E8);
    hot <= 1'b1; wt(10); chk(curMa, 12'h1F4);
    hot <= 1'b0; wt(10); chk(curMa, 12'h3E8);
  endtask : t_fast
  task automatic t_target();
    logic [15:0] v[4] = '{16'h0D48, 16'h1158, 16'h1159, 16'h0DAC};
    logic [15:0] e[4] = '{16'h0E10, 16'h1158, 16'h1158, 16'h0DAC};
    for (int i = 0; i < 4; i++) begin
      bus(OFS_TARGET, 1, {16'h0000, v[i]});
      bus(OFS_TARGET, 0, 0); chk(rd, {16'h0000, e[i]}); chk(target, e[i]);
    end
  endtask : t_target
  task automatic t_term();
    for (int i = 0; i < 2; i++) begin
      bus(OFS_IRQ_STATUS, 1, 32'h0000_000F);
      near <= 1'b1; wt(10); chk(cvMode, 1);
      if (i == 0) begin
        bus(OFS_CTRL, 1, 32'h0000_0001);
        taper <= 1'b1; wt(10); chk(statPin, 0); chk(cvMode, 1);
        bus(OFS_CTRL, 1, 32'h0000_0003);
      end
      taper <= 1'b1; wt(10); chk(statPin, 1);
      bus(OFS_IRQ_STATUS, 0, 0); chk(rd & 32'h2, 32'h2);
      near <= 1'b0; taper <= 1'b0; wt(10); chk(statPin, 1);
      if (i == 0) conf <= 1'b1;
      else rech <= 1'b1;
      wt(10); chk(statPin, 0);
      bus(OFS_IRQ_STATUS, 0, 0); chk(rd & 32'hC, i == 0 ? 32'hC : 32'h8);
      conf <= 1'b0; rech <= 1'b0; wt(10);
    end
  endtask : t_term
  task automatic t_irq();
    bus(OFS_IRQ_STATUS, 1, 32'h0000_000F); bus(OFS_IRQ_MASK, 1, 32'h0000_0001);
    wt(2); chk(irq, 0);
    fpulse(); wt(6); chk(irq, 1);
    bus(OFS_IRQ_MASK, 1, 0); wt(2); chk(irq, 0);
    bus(OFS_IRQ_MASK, 1, 32'h0000_0001); wt(2); chk(irq, 1);
    bus(OFS_IRQ_STATUS, 1, 32'h0000_0001); wt(2); chk(irq, 0);
  endtask : t_irq
  task automatic t_pulse();
    bus(OFS_CTRL, 1, 32'h0000_0013); wt(10); chk(floatMode, 1); chk(statPin, 1);
    fpulse(); fpulse(); wt(50); chk(lastLow, 16'h001E);
    bus(OFS_CTRL, 1, 32'h0000_0012); fpulse(); wt(10); chk(statPin, 1);
    wt(30); chk(lastLow, 16'h001E);
    bus(OFS_CTRL, 1, 32'h0000_0003); wt(10); chk(floatMode, 0); chk(statPin, 0);
  endtask : t_pulse
  task automatic t_hiz();
    for (int i = 0; i < 3; i++) begin
      if (i == 2) offIn <= 1'b1;
      else bus(OFS_CTRL, 1, i == 0 ? 32'h0000_0007 : 32'h0000_0013);
      wt(10); chk(floatMode, 1); chk(curMa, 0);
      if (i == 2) offIn <= 1'b0;
      else bus(OFS_CTRL, 1, 32'h0000_0003);
      wt(10); chk(floatMode, 0);
    end
    bus(OFS_IRQ_STATUS, 1, 32'h0000_000F); bus(OFS_CTRL, 1, 32'h0000_000B);
    wt(10); bus(OFS_IRQ_STATUS, 0, 0); chk(rd & 32'h8, 32'h8);
    bus(OFS_CTRL, 0, 0); chk(rd & 32'h8, 32'h0);
  endtask : t_hiz

  task automatic stop_test();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  initial begin
    #(100 * 20000);
    error_cnt++;
    stop_test();
  end
  initial begin
    wt(12); rst <= 1'b0; wt(1);
    t_regs(); t_fast(); t_target(); t_term(); t_irq(); t_pulse(); t_hiz();
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
